/* File: hw/ssps_defines.svh */
`ifndef SSPS_DEFINES_SVH
`define SSPS_DEFINES_SVH
`define SSPS_STATUS_ADDR 8'h94
`define SSPS_STATUS_RESET 8'h00
`define SSPS_BIT_DNA 5
`define SSPS_BIT_STOP 4
`define SSPS_BIT_START 3
`define SSPS_BIT_DIR 2
`define SSPS_BIT_UA 1
`define SSPS_BIT_BF 0
`endif

/* File: hw/ssps_pkg.sv */
package ssps_pkg;
  typedef enum logic [1:0] {
    SSPS_IDLE = 2'b00,
    SSPS_ADDR = 2'b01,
    SSPS_DATA = 2'b10
  } ssps_phase_t;
  typedef enum logic {
    SSPS_MODE_SPI = 1'b0,
    SSPS_MODE_I2C = 1'b1
  } ssps_mode_t;
endpackage

/* File: hw/ssps_sync2.sv */
`timescale 1ns/1ns
module ssps_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ssps_sync_t;
  ssps_sync_t st_reg;
  ssps_sync_t st_next;
  // Elaboration guard
  if (WIDTH < 1) begin : g_width_check
    $error("ssps_sync2 width must be positive");
  end
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q = st_reg.s2;
endmodule

/* File: hw/ssps_status.sv */
`timescale 1ns/1ns
`include "ssps_defines.svh"
// Behaviour
// - Port runs in exactly one mode at a time, SPI or I2C.
// - Read-only status at 94h, all zero after reset, bits 7-6 zero.
// - I2C: data flag zero after address byte, one after data byte.
// - I2C: stop flag marks stop seen last; cleared by reset or disable.
// - I2C: start flag marks start seen last; cleared by reset or disable.
// - I2C: direction flag captures read/write bit of matching address.
// - Direction value valid from match until next start, stop or acknowledge.
// - Buffer full set when received byte complete or transmit byte loaded, zero after buffer read or shift-out done.
module ssps_status (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic port_enable,
  input wire logic mode_i2c,
  input wire logic i2c_start_det,
  input wire logic i2c_stop_det,
  input wire logic i2c_ack_det,
  input wire logic i2c_addr_match,
  input wire logic i2c_rw_bit,
  input wire logic byte_done_addr,
  input wire logic byte_done_data,
  input wire logic rx_complete,
  input wire logic buf_read,
  input wire logic tx_load,
  input wire logic tx_done,
  input wire logic addr_update_req,
  input wire logic addr_update_done,
  output logic [7:0] sync_port_status,
  output logic dir_valid
);
  typedef struct packed {
    logic dna;
    logic stop;
    logic start;
    logic dir;
    logic dvalid;
    logic ua;
    logic bf;
    logic [7:0] rdata;
    logic [7:0] status;
  } ssps_state_t;
  ssps_state_t st_reg;
  ssps_state_t st_next;
  logic rst_int_n;
  logic [7:0] stat_now;

  // ==========================================
  // Reset release
  // Async assert, release aligned to clk so no flop sees a runt recovery
  ssps_sync2 #(
    .WIDTH(1)
  ) rst_sync (
    .clk(clk),
    .rstn(rstn),
    .d(1'b1),
    .q(rst_int_n)
  );

  // ==========================================
  // Flag logic
  always_comb begin
    st_next = st_reg;
    if (mode_i2c == ssps_pkg::SSPS_MODE_I2C) begin
      if (byte_done_addr) begin
        st_next.dna = 1'b0;
      end else if (byte_done_data) begin
        st_next.dna = 1'b1;
      end
      if (i2c_stop_det) begin
        st_next.stop = 1'b1;
        st_next.start = 1'b0;
      end else if (i2c_start_det) begin
        st_next.start = 1'b1;
        st_next.stop = 1'b0;
      end
      if (i2c_start_det || i2c_stop_det || i2c_ack_det) begin
        st_next.dvalid = 1'b0;
      end
      if (i2c_addr_match) begin
        st_next.dir = i2c_rw_bit;
        st_next.dvalid = 1'b1;
      end
      // Address update; request wins over done
      if (addr_update_req) begin
        st_next.ua = 1'b1;
      end else if (addr_update_done) begin
        st_next.ua = 1'b0;
      end
    end else begin
      st_next.dna = 1'b0;
      st_next.stop = 1'b0;
      st_next.start = 1'b0;
      st_next.dir = 1'b0;
      st_next.dvalid = 1'b0;
      st_next.ua = 1'b0;
    end
    // Receive or transmit fill, set wins over read or shift-out done
    if (rx_complete || tx_load) begin
      st_next.bf = 1'b1;
    end else if (buf_read || tx_done) begin
      st_next.bf = 1'b0;
    end
    if (!port_enable) begin
      st_next.stop = 1'b0;
      st_next.start = 1'b0;
    end
    st_next.status = 8'h00;
    st_next.status[`SSPS_BIT_DNA] = st_next.dna;
    st_next.status[`SSPS_BIT_STOP] = st_next.stop;
    st_next.status[`SSPS_BIT_START] = st_next.start;
    st_next.status[`SSPS_BIT_DIR] = st_next.dir;
    st_next.status[`SSPS_BIT_UA] = st_next.ua;
    st_next.status[`SSPS_BIT_BF] = st_next.bf;
    st_next.rdata = 8'h00;
    if (reg_rd && reg_addr == `SSPS_STATUS_ADDR) begin
      st_next.rdata = st_reg.status;
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_reg.dna <= 1'b0;
      st_reg.stop <= 1'b0;
      st_reg.start <= 1'b0;
      st_reg.dir <= 1'b0;
      st_reg.dvalid <= 1'b0;
      st_reg.ua <= 1'b0;
      st_reg.bf <= 1'b0;
      st_reg.rdata <= 8'h00;
      st_reg.status <= `SSPS_STATUS_RESET;
    end else begin
      st_reg.dna <= st_next.dna;
      st_reg.stop <= st_next.stop;
      st_reg.start <= st_next.start;
      st_reg.dir <= st_next.dir;
      st_reg.dvalid <= st_next.dvalid;
      st_reg.ua <= st_next.ua;
      st_reg.bf <= st_next.bf;
      st_reg.rdata <= st_next.rdata;
      st_reg.status <= st_next.status;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign sync_port_status = st_reg.status;
  assign dir_valid = st_reg.dvalid;
  assign stat_now = st_reg.status;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_int_n);
  a_upper_zero: assert property (stat_now[7:6] == 2'b00)
    else $error("upper status bits set");
  a_read_data: assert property (reg_rd && reg_addr == `SSPS_STATUS_ADDR |=> reg_rdata == $past(stat_now))
    else $error("read data wrong");
  a_read_other: assert property (reg_rd && reg_addr != `SSPS_STATUS_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_write_quiet: assert property (reg_wr && !reg_rd |=> reg_rdata == 8'h00)
    else $error("write produced read data");
  a_dna_addr: assert property (mode_i2c && byte_done_addr |=> !stat_now[`SSPS_BIT_DNA])
    else $error("data flag not cleared");
  a_dna_data: assert property (mode_i2c && !byte_done_addr && byte_done_data |=> stat_now[`SSPS_BIT_DNA])
    else $error("data flag not set");
  a_stop_set: assert property (mode_i2c && port_enable && i2c_stop_det |=> stat_now[`SSPS_BIT_STOP])
    else $error("stop flag not set");
  a_stop_prio: assert property (mode_i2c && i2c_stop_det |=> !stat_now[`SSPS_BIT_START])
    else $error("start kept over stop");
  a_stop_drop: assert property (mode_i2c && i2c_start_det && !i2c_stop_det |=> !stat_now[4])
    else $error("stop kept after start");
  a_start_set: assert property (mode_i2c && port_enable && !i2c_stop_det && i2c_start_det |=> stat_now[3])
    else $error("start flag not set");
  a_dis_clear: assert property (!port_enable |=> stat_now[4:3] == 2'b00)
    else $error("disable kept flags");
  a_dir_cap: assert property (mode_i2c && i2c_addr_match |=> stat_now[2] == $past(i2c_rw_bit) && dir_valid)
    else $error("direction not captured");
  a_dir_hold: assert property (mode_i2c && !i2c_addr_match |=> stat_now[2] == $past(stat_now[2]))
    else $error("direction changed without match");
  a_dir_win: assert property (mode_i2c && !i2c_addr_match && i2c_ack_det |=> !dir_valid)
    else $error("direction window open after ack");
  a_dir_end: assert property (!i2c_addr_match && (i2c_start_det || i2c_stop_det) |=> !dir_valid)
    else $error("direction window open after condition");
  a_bf_rx: assert property (rx_complete |=> stat_now[0])
    else $error("buffer full missed");
  a_bf_read: assert property (buf_read && !rx_complete && !tx_load |=> !stat_now[0])
    else $error("buffer full kept after read");
  a_bf_tx: assert property (tx_load ##1 (!rx_complete && !tx_load && !buf_read && !tx_done) |=> stat_now[0])
    else $error("buffer full dropped");
  a_bf_done: assert property (tx_done && !rx_complete && !tx_load |=> !stat_now[0])
    else $error("buffer full kept after shift out");
  a_ua_set: assert property (mode_i2c && addr_update_req |=> stat_now[1])
    else $error("update flag missed");
  a_ua_clear: assert property (mode_i2c && !addr_update_req && addr_update_done |=> !stat_now[1])
    else $error("update flag kept");
  a_spi_quiet: assert property (!mode_i2c |=> stat_now[5:1] == 5'h00 && !dir_valid)
    else $error("i2c flags in spi");
  // Main scenarios
  c_start: cover property (mode_i2c && i2c_start_det ##1 stat_now[3]);
  c_read: cover property (mode_i2c && i2c_addr_match && i2c_rw_bit);
  c_rx: cover property (rx_complete ##[1:4] buf_read);
  c_ua: cover property (addr_update_req ##[1:8] addr_update_done);
  c_tx: cover property (tx_load ##[1:4] tx_done);
endmodule

/* File: tb/ssps_peer.sv */
`timescale 1ns/1ns
// ==========
// Far-side engine
// Each command leaves here as a one-cycle pulse on the edge after it is asked for
module ssps_peer (
  input wire logic clk,
  input wire logic [12:0] cmd,
  output logic [12:0] ev
);
  always_ff @(posedge clk) begin
    ev <= cmd;
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic [12:0] cmd; logic [8:0] exp;} ssps_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic port_enable = 1'b1;
  logic mode_i2c = 1'b1;
  logic [12:0] cmd = 13'h0;
  logic [12:0] ev;
  logic [7:0] reg_rdata;
  logic [7:0] sync_port_status;
  logic dir_valid;
  int mismatches = 0;
  int n_compared = 0;
  // Cmd bits: start stop ack match rw addr_done data_done rx buf_read tx_load tx_done ua_req ua_done
  ssps_row_t rows[16] = '{'{13'h1000, 9'h008}, '{13'h0380, 9'h10c}, '{13'h0040, 9'h12c},
    '{13'h0280, 9'h108}, '{13'h0040, 9'h128}, '{13'h0020, 9'h129}, '{13'h0010, 9'h128},
    '{13'h0002, 9'h12a}, '{13'h0001, 9'h128}, '{13'h0008, 9'h129}, '{13'h0004, 9'h128},
    '{13'h0400, 9'h028}, '{13'h0800, 9'h030}, '{13'h1800, 9'h030}, '{13'h1000, 9'h028},
    '{13'h0030, 9'h029}};
  always #5 clk = ~clk;
  ssps_peer peer (.clk(clk), .cmd(cmd), .ev(ev));
  ssps_status DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_enable(port_enable), .mode_i2c(mode_i2c),
    .i2c_start_det(ev[12]), .i2c_stop_det(ev[11]), .i2c_ack_det(ev[10]), .i2c_addr_match(ev[9]),
    .i2c_rw_bit(ev[8]), .byte_done_addr(ev[7]), .byte_done_data(ev[6]), .rx_complete(ev[5]),
    .buf_read(ev[4]), .tx_load(ev[3]), .tx_done(ev[2]), .addr_update_req(ev[1]),
    .addr_update_done(ev[0]), .sync_port_status(sync_port_status), .dir_valid(dir_valid));
  // ==========
  // Tasks
  task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task pulse(input logic [12:0] v);
    @(posedge clk);
    cmd <= v;
    @(posedge clk);
    cmd <= 13'h0;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    n_compared++;
    if (reg_rdata !== e) begin
      mismatches++;
      $display("unexpected reg_rdata expected %h seen %h", e, reg_rdata);
    end
  endtask
  task level_step;
    @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========
  // Watchdog, far beyond the fewer than a hundred cycles the tests need
  initial begin
    #50000;
    mismatches++;
    end_sim;
  end
  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      pulse(rows[i].cmd);
      chk("status", rows[i].exp, {dir_valid, sync_port_status}); // Flags
    end
    rd(8'h94, 8'h29); // Read
    rd(8'h95, 8'h00); // Unmapped
    @(posedge clk);
    reg_addr <= 8'h94;
    reg_wdata <= 8'hff;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    rd(8'h94, 8'h29); // Write ignored
    @(posedge clk);
    port_enable <= 1'b0;
    level_step;
    chk("status", 9'h021, {dir_valid, sync_port_status}); // Disable
    @(posedge clk);
    port_enable <= 1'b1;
    mode_i2c <= 1'b0;
    level_step;
    chk("status", 9'h001, {dir_valid, sync_port_status}); // Spi
    pulse(13'h0010);
    chk("status", 9'h000, {dir_valid, sync_port_status}); // Spi drain
    pulse(13'h0020);
    chk("status", 9'h001, {dir_valid, sync_port_status}); // Spi fill
    @(posedge clk);
    rstn <= 1'b0;
    level_step;
    chk("status", 9'h000, {dir_valid, sync_port_status}); // Reset
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h94, 8'h00); // Reset value
    pulse(13'h0020);
    chk("status", 9'h001, {dir_valid, sync_port_status}); // Alive after reset
    end_sim;
  end
endmodule
